// >>> bao_regs.svh
// bao_regs.svh: register file offsets, flag positions, opcode and mode codes, bus answers.
// assumes inclusion by bare name before the package and the design modules.
`ifndef BAO_REGS_SVH
`define BAO_REGS_SVH

// control registers at the top of the register file
`define BAO_OFS_INTERRUPT_MASK 8'hfb
`define BAO_OFS_CONDITION_FLAGS 8'hfc
`define BAO_OFS_BANK_SELECT 8'hfd
`define BAO_OFS_SPARE_SCRATCH 8'hfe
`define BAO_OFS_STACK_POINTER_LOW 8'hff
`define BAO_CTRL_BASE 8'hfb

// working register page, expanded group window and interrupt global enable bit
`define BAO_WORK_PAGE 4'he
`define BAO_ERF_WINDOW 4'h0
`define BAO_GLOBAL_EN_BIT 7

// reset values
`define BAO_RST_BYTE 8'h00
`define BAO_RST_PC 16'h0000

// operation selectors (upper opcode nibble)
`define BAO_OP_SUB 4'h2
`define BAO_OP_SUB_BORROW 4'h3
`define BAO_OP_OR 4'h4
`define BAO_OP_TEST_COMPL 4'h6
`define BAO_OP_TEST_MASK 4'h7
`define BAO_OP_XOR 4'hb

// operand mode pairs (lower opcode nibble)
`define BAO_MODE_WW 4'h2
`define BAO_MODE_WI 4'h3
`define BAO_MODE_RR 4'h4
`define BAO_MODE_RI 4'h5
`define BAO_MODE_RL 4'h6
`define BAO_MODE_IL 4'h7

// whole-byte opcodes and the pop/push pair mask
`define BAO_OPC_POP 8'h50
`define BAO_OPC_PUSH 8'h70
`define BAO_OPC_PAIR_MASK 8'hfe
`define BAO_OPC_RETURN 8'haf
`define BAO_OPC_CARRY_CLEAR 8'hcf
`define BAO_OPC_CARRY_SET 8'hdf
`define BAO_OPC_CARRY_INVERT 8'hef
`define BAO_OPC_INT_DISABLE 8'h8f
`define BAO_OPC_INT_ENABLE 8'h9f
`define BAO_OPC_INT_RETURN 8'hbf
`define BAO_OPC_NOP 8'hff

// bus side
`define BAO_AXI_UNMAPPED_BIT 11
`define BAO_RESP_OKAY 2'b00
`define BAO_RESP_SLVERR 2'b10

`endif

// >>> bao_pkg.sv
// bao_pkg.sv: types shared by the decoder core and its register memory.
// assumes bao_regs.svh holds the numeric constants.
package bao_pkg;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_PTR = 6'h02,
    ST_CAP = 6'h04,
    ST_DST = 6'h08,
    ST_SRC = 6'h10,
    ST_EXE = 6'h20
  } bao_state_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] op1;
    logic [7:0] op2;
  } bao_instr_t;

  typedef struct packed {
    logic c;
    logic z;
    logic s;
    logic v;
    logic d;
    logic h;
    logic [1:0] user;
  } bao_flags_t;

endpackage

// >>> bao_regfile.sv
// bao_regfile.sv: 512-byte register memory, one write port, one registered read port.
// assumes the core keeps the control bytes out of it and drives ce for the whole block.
`timescale 1ns/1ps
module bao_regfile import bao_pkg::*; (
  input wire logic mclk,
  input wire logic ce,
  input wire logic wen,
  input wire logic [8:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [8:0] raddr,
  output logic [7:0] rdata
);

  logic [7:0] mem [0:511];

  // no reset on the array: contents are undefined until written
  always_ff @(posedge mclk) begin
    if (ce) begin
      if (wen) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end

endmodule

// >>> bao_core.sv
// bao_core.sv: 8-bit op decoder and datapath with its control registers on AXI4-Lite.
// assumes one clock, synchronous reset and a source that holds instr until taken.
// Contract
// - OR stores dst or src, z s, v cleared
// - pop loads from stack then increments pointer
// - push decrements pointer then stores source
// - return reloads pc, pointer advances two
// - subtract with borrow, arithmetic flags, decimal set
// - subtract, arithmetic flags, decimal flag set
// - complement test ands inverted dst, no store
// - mask test ands dst and src, no store
// - xor stores dst xor src, v cleared
// - upper nibble picks the operation
// - lower nibble picks operand mode pair
// - single-byte ops need no operand bytes
// - interrupt mask read/write at fb
// - flag register read/write at fc
// - bank select pointer read/write at fd
// - spare scratch byte read/write at fe
// - stack pointer low at ff, used by stack
// - bank pointer high selects work, low expanded
`timescale 1ns/1ps
`include "bao_regs.svh"
module bao_core import bao_pkg::*; (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic instr_valid,
  output logic instr_ready,
  input wire bao_instr_t instr,
  output logic [15:0] pc,
  output logic exec_done,
  output logic bad_opcode,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [11:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);

  bao_state_t st_q;
  bao_instr_t instr_q;
  bao_flags_t flags_q, nf;
  logic [7:0] interrupt_mask_q, bank_select_pointer_q, spare_scratch_q, stack_pointer_low_q;
  logic [15:0] pc_q;
  logic [7:0] ptr_q, dst_q, rd_val, mem_rdata, ctrl_val_q, b_val, alu_res;
  logic ctrl_hit_q, done_q, bad_q;
  logic [3:0] hi, lo;
  logic is_alu, arith, stores, is_pop, is_push, is_ret, is_interrupt_return_op, known, use_imm;
  logic [7:0] ptr_a, dst_a, src_a, core_waddr, core_wdata, wdata_m;
  logic [1:0] len;
  logic [8:0] diff9, raddr_p, waddr_p;
  logic [4:0] half5;
  logic cin, core_wen, wen, instr_fire, in_exe;
  logic aw_have_q, w_have_q, w_strb0_q, bvalid_q, rd_pend_q, ar_bad_q, rvalid_q;
  logic [11:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic axi_wfire, ar_fire;

  // a register operand in the work page is redirected to the selected working group
  function automatic logic [7:0] rmap(input logic [7:0] a, input logic [7:0] bsel);
    return (a[7:4] == `BAO_WORK_PAGE) ? {bsel[7:4], a[3:0]} : a;
  endfunction

  // low window goes to the active expanded group when one is selected
  function automatic logic [8:0] phys(input logic [7:0] a, input logic [7:0] bsel);
    if (a[7:4] == `BAO_ERF_WINDOW && bsel[3:0] != 4'h0) begin
      return {1'b1, bsel[3:0], a[3:0]};
    end
    return {1'b0, a};
  endfunction

  function automatic logic is_ctrl(input logic [8:0] p);
    return !p[8] && (p[7:0] >= `BAO_CTRL_BASE);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // decode

  assign hi = instr_q.opcode[7:4];
  assign lo = instr_q.opcode[3:0];
  assign is_alu = (lo >= `BAO_MODE_WW) && (lo <= `BAO_MODE_IL) && (hi == `BAO_OP_SUB ||
    hi == `BAO_OP_SUB_BORROW || hi == `BAO_OP_OR || hi == `BAO_OP_TEST_COMPL ||
    hi == `BAO_OP_TEST_MASK || hi == `BAO_OP_XOR);
  assign arith = (hi == `BAO_OP_SUB) || (hi == `BAO_OP_SUB_BORROW);
  assign stores = is_alu && hi != `BAO_OP_TEST_COMPL && hi != `BAO_OP_TEST_MASK;
  assign is_pop = (instr_q.opcode & `BAO_OPC_PAIR_MASK) == `BAO_OPC_POP;
  assign is_push = (instr_q.opcode & `BAO_OPC_PAIR_MASK) == `BAO_OPC_PUSH;
  assign is_ret = instr_q.opcode == `BAO_OPC_RETURN;
  assign is_interrupt_return_op = instr_q.opcode == `BAO_OPC_INT_RETURN;
  assign known = is_alu || is_pop || is_push || is_ret || is_interrupt_return_op ||
    instr_q.opcode == `BAO_OPC_CARRY_CLEAR || instr_q.opcode == `BAO_OPC_CARRY_SET ||
    instr_q.opcode == `BAO_OPC_CARRY_INVERT || instr_q.opcode == `BAO_OPC_INT_DISABLE ||
    instr_q.opcode == `BAO_OPC_INT_ENABLE || instr_q.opcode == `BAO_OPC_NOP;

  always_comb begin
    ptr_a = stack_pointer_low_q;
    dst_a = stack_pointer_low_q;
    src_a = stack_pointer_low_q + 8'h01;
    use_imm = 1'b0;
    len = 2'd1;
    if (is_alu) begin
      len = 2'd3;
      case (lo)
        `BAO_MODE_WW: begin
          dst_a = {bank_select_pointer_q[7:4], instr_q.op1[7:4]};
          src_a = {bank_select_pointer_q[7:4], instr_q.op1[3:0]};
          len = 2'd2;
        end
        `BAO_MODE_WI: begin
          ptr_a = {bank_select_pointer_q[7:4], instr_q.op1[3:0]};
          dst_a = {bank_select_pointer_q[7:4], instr_q.op1[7:4]};
          src_a = rmap(ptr_q, bank_select_pointer_q);
          len = 2'd2;
        end
        `BAO_MODE_RR: begin
          dst_a = rmap(instr_q.op2, bank_select_pointer_q);
          src_a = rmap(instr_q.op1, bank_select_pointer_q);
        end
        `BAO_MODE_RI: begin
          ptr_a = rmap(instr_q.op1, bank_select_pointer_q);
          dst_a = rmap(instr_q.op2, bank_select_pointer_q);
          src_a = rmap(ptr_q, bank_select_pointer_q);
        end
        `BAO_MODE_RL: begin
          dst_a = rmap(instr_q.op1, bank_select_pointer_q);
          use_imm = 1'b1;
        end
        default: begin
          ptr_a = rmap(instr_q.op1, bank_select_pointer_q);
          dst_a = rmap(ptr_q, bank_select_pointer_q);
          use_imm = 1'b1;
        end
      endcase
    end else if (is_pop) begin
      ptr_a = rmap(instr_q.op1, bank_select_pointer_q);
      dst_a = rmap(instr_q.opcode[0] ? ptr_q : instr_q.op1, bank_select_pointer_q);
      src_a = stack_pointer_low_q;
      len = 2'd2;
    end else if (is_push) begin
      ptr_a = rmap(instr_q.op1, bank_select_pointer_q);
      src_a = rmap(instr_q.opcode[0] ? ptr_q : instr_q.op1, bank_select_pointer_q);
      len = 2'd2;
    end else if (is_interrupt_return_op) begin
      dst_a = stack_pointer_low_q + 8'h01;
      src_a = stack_pointer_low_q + 8'h02;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // arithmetic and flag effects

  assign b_val = use_imm ? instr_q.op2 : rd_val;
  assign cin = (hi == `BAO_OP_SUB_BORROW) ? flags_q.c : 1'b0;
  assign diff9 = {1'b0, dst_q} - {1'b0, b_val} - {8'h00, cin};
  assign half5 = {1'b0, dst_q[3:0]} - {1'b0, b_val[3:0]} - {4'h0, cin};

  always_comb begin
    case (hi)
      `BAO_OP_OR: alu_res = dst_q | b_val;
      `BAO_OP_TEST_COMPL: alu_res = ~dst_q & b_val;
      `BAO_OP_TEST_MASK: alu_res = dst_q & b_val;
      `BAO_OP_XOR: alu_res = dst_q ^ b_val;
      default: alu_res = diff9[7:0];
    endcase
  end

  always_comb begin
    nf = flags_q;
    if (is_alu) begin
      nf.z = (alu_res == 8'h00);
      nf.s = alu_res[7];
      nf.v = 1'b0;
      if (arith) begin
        nf.c = diff9[8];
        nf.v = (dst_q[7] != b_val[7]) && (alu_res[7] != dst_q[7]);
        nf.d = 1'b1;
        nf.h = half5[4];
      end
    end else if (is_interrupt_return_op) begin
      nf = ptr_q;
    end else if (instr_q.opcode == `BAO_OPC_CARRY_CLEAR) begin
      nf.c = 1'b0;
    end else if (instr_q.opcode == `BAO_OPC_CARRY_SET) begin
      nf.c = 1'b1;
    end else if (instr_q.opcode == `BAO_OPC_CARRY_INVERT) begin
      nf.c = ~flags_q.c;
    end
  end

  assign in_exe = (st_q == ST_EXE) && ce;
  assign core_wen = (st_q == ST_EXE) && (stores || is_pop || is_push);
  assign core_waddr = is_push ? stack_pointer_low_q - 8'h01 : dst_a;
  assign core_wdata = is_alu ? alu_res : rd_val;

  ////////////////////////////////////////////////////////////////////////////
  // sequencing: every instruction walks the same six states

  assign instr_ready = (st_q == ST_IDLE) && ce && !rd_pend_q && !s_axi_arvalid &&
    !(aw_have_q && w_have_q);
  assign instr_fire = instr_valid && instr_ready;

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= ST_IDLE;
    end else if (ce) begin
      case (st_q)
        ST_IDLE: st_q <= instr_fire ? ST_PTR : ST_IDLE;
        ST_PTR: st_q <= ST_CAP;
        ST_CAP: st_q <= ST_DST;
        ST_DST: st_q <= ST_SRC;
        ST_SRC: st_q <= ST_EXE;
        ST_EXE: st_q <= ST_IDLE;
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      instr_q <= '0;
      ptr_q <= `BAO_RST_BYTE;
      dst_q <= `BAO_RST_BYTE;
    end else if (ce) begin
      if (instr_fire) begin
        instr_q <= instr;
      end
      if (st_q == ST_CAP) begin
        ptr_q <= rd_val;
      end
      if (st_q == ST_SRC) begin
        dst_q <= rd_val;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pc_q <= `BAO_RST_PC;
      done_q <= 1'b0;
      bad_q <= 1'b0;
    end else if (ce) begin
      done_q <= st_q == ST_EXE;
      bad_q <= (st_q == ST_EXE) && !known;
      if (st_q == ST_EXE) begin
        if (is_ret || is_interrupt_return_op) begin
          pc_q <= {dst_q, rd_val};
        end else begin
          pc_q <= pc_q + {14'h0000, len};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // memory and control register access

  always_comb begin
    case (st_q)
      ST_PTR: raddr_p = phys(ptr_a, bank_select_pointer_q);
      ST_DST: raddr_p = phys(dst_a, bank_select_pointer_q);
      ST_SRC: raddr_p = phys(src_a, bank_select_pointer_q);
      default: raddr_p = s_axi_araddr[10:2];
    endcase
  end

  // control bytes are sampled at issue so they line up with the memory latency
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_hit_q <= 1'b0;
      ctrl_val_q <= `BAO_RST_BYTE;
    end else if (ce) begin
      ctrl_hit_q <= is_ctrl(raddr_p);
      case (raddr_p[7:0])
        `BAO_OFS_INTERRUPT_MASK: ctrl_val_q <= interrupt_mask_q;
        `BAO_OFS_CONDITION_FLAGS: ctrl_val_q <= flags_q;
        `BAO_OFS_BANK_SELECT: ctrl_val_q <= bank_select_pointer_q;
        `BAO_OFS_SPARE_SCRATCH: ctrl_val_q <= spare_scratch_q;
        default: ctrl_val_q <= stack_pointer_low_q;
      endcase
    end
  end

  assign rd_val = ctrl_hit_q ? ctrl_val_q : mem_rdata;
  assign wen = core_wen || (axi_wfire && w_strb0_q && !aw_addr_q[`BAO_AXI_UNMAPPED_BIT]);
  assign waddr_p = axi_wfire ? aw_addr_q[10:2] : phys(core_waddr, bank_select_pointer_q);
  assign wdata_m = axi_wfire ? w_data_q : core_wdata;

  bao_regfile u_mem (
    .mclk(mclk),
    .ce(ce),
    .wen(wen && !is_ctrl(waddr_p)),
    .waddr(waddr_p),
    .wdata(wdata_m),
    .raddr(raddr_p),
    .rdata(mem_rdata)
  );

  // an explicit store to a control byte overrides the instruction's own effect on it
  always_ff @(posedge mclk) begin
    if (rst) begin
      interrupt_mask_q <= `BAO_RST_BYTE;
      flags_q <= `BAO_RST_BYTE;
      bank_select_pointer_q <= `BAO_RST_BYTE;
      spare_scratch_q <= `BAO_RST_BYTE;
      stack_pointer_low_q <= `BAO_RST_BYTE;
    end else if (ce) begin
      if (st_q == ST_EXE) begin
        flags_q <= nf;
        if (is_pop) stack_pointer_low_q <= stack_pointer_low_q + 8'h01;
        if (is_push) stack_pointer_low_q <= stack_pointer_low_q - 8'h01;
        if (is_ret) stack_pointer_low_q <= stack_pointer_low_q + 8'h02;
        if (is_interrupt_return_op) stack_pointer_low_q <= stack_pointer_low_q + 8'h03;
        if (instr_q.opcode == `BAO_OPC_INT_DISABLE) interrupt_mask_q[`BAO_GLOBAL_EN_BIT] <= 1'b0;
        if (instr_q.opcode == `BAO_OPC_INT_ENABLE || is_interrupt_return_op) begin
          interrupt_mask_q[`BAO_GLOBAL_EN_BIT] <= 1'b1;
        end
      end
      if (wen && is_ctrl(waddr_p)) begin
        case (waddr_p[7:0])
          `BAO_OFS_INTERRUPT_MASK: interrupt_mask_q <= wdata_m;
          `BAO_OFS_CONDITION_FLAGS: flags_q <= wdata_m;
          `BAO_OFS_BANK_SELECT: bank_select_pointer_q <= wdata_m;
          `BAO_OFS_SPARE_SCRATCH: spare_scratch_q <= wdata_m;
          default: stack_pointer_low_q <= wdata_m;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: bus access waits for the core to be idle

  assign s_axi_awready = !aw_have_q && ce;
  assign s_axi_wready = !w_have_q && ce;
  assign s_axi_arready = (st_q == ST_IDLE) && !rd_pend_q && !rvalid_q && ce;
  assign axi_wfire = aw_have_q && w_have_q && !bvalid_q && (st_q == ST_IDLE) && ce;
  assign ar_fire = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge mclk) begin
    if (rst) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 12'h000;
      w_data_q <= `BAO_RST_BYTE;
      w_strb0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `BAO_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata[7:0];
        w_strb0_q <= s_axi_wstrb[0];
      end
      if (axi_wfire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= aw_addr_q[`BAO_AXI_UNMAPPED_BIT] ? `BAO_RESP_SLVERR : `BAO_RESP_OKAY;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_pend_q <= 1'b0;
      ar_bad_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `BAO_RESP_OKAY;
    end else if (ce) begin
      rd_pend_q <= ar_fire;
      if (ar_fire) ar_bad_q <= s_axi_araddr[`BAO_AXI_UNMAPPED_BIT];
      if (rd_pend_q) begin
        rvalid_q <= 1'b1;
        rdata_q <= ar_bad_q ? 32'h0000_0000 : {24'h00_0000, rd_val};
        rresp_q <= ar_bad_q ? `BAO_RESP_SLVERR : `BAO_RESP_OKAY;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign pc = pc_q;
  assign exec_done = done_q;
  assign bad_opcode = bad_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence fire_s;
    instr_fire;
  endsequence
  sequence run4_s;
    ce [*4];
  endsequence

  walk_to_exe_a: assert property (fire_s ##1 run4_s |=> st_q == ST_EXE)
    else $error("instruction did not reach execute in five cycles");
  or_flags_a: assert property (in_exe && is_alu && hi == `BAO_OP_OR |=>
    flags_q.z == (($past(dst_q) | $past(b_val)) == 8'h00) && !flags_q.v &&
    flags_q.c == $past(flags_q.c) && flags_q.h == $past(flags_q.h))
    else $error("or flag effect wrong");
  pop_step_a: assert property (in_exe && is_pop && !(wen && is_ctrl(waddr_p)) |=>
    stack_pointer_low_q == $past(stack_pointer_low_q) + 8'h01 && flags_q == $past(flags_q))
    else $error("pop did not step stack pointer up");
  push_step_a: assert property (in_exe && is_push && !(wen && is_ctrl(waddr_p)) |->
    core_waddr == stack_pointer_low_q - 8'h01 ##1
    stack_pointer_low_q == $past(stack_pointer_low_q) - 8'h01)
    else $error("push address or stack pointer wrong");
  ret_reload_a: assert property (in_exe && is_ret |=>
    pc_q == {$past(dst_q), $past(rd_val)} &&
    stack_pointer_low_q == $past(stack_pointer_low_q) + 8'h02 && flags_q == $past(flags_q))
    else $error("return reload wrong");
  borrow_sub_a: assert property (in_exe && is_alu && hi == `BAO_OP_SUB_BORROW |=>
    flags_q.d && flags_q.c == ({1'b0, $past(dst_q)} < {1'b0, $past(b_val)} + {8'h00, $past(cin)}))
    else $error("subtract with borrow flags wrong");
  plain_sub_a: assert property (in_exe && is_alu && hi == `BAO_OP_SUB |=>
    flags_q.d && flags_q.c == ($past(dst_q) < $past(b_val)) && flags_q.s == $past(alu_res[7]))
    else $error("subtract flags wrong");
  compl_test_a: assert property (in_exe && is_alu && hi == `BAO_OP_TEST_COMPL |->
    !core_wen ##1 flags_q.z == ((~$past(dst_q) & $past(b_val)) == 8'h00) && !flags_q.v)
    else $error("complement test stored or flagged wrong");
  mask_test_a: assert property (in_exe && is_alu && hi == `BAO_OP_TEST_MASK |->
    !core_wen ##1 flags_q.z == (($past(dst_q) & $past(b_val)) == 8'h00) &&
    flags_q.d == $past(flags_q.d))
    else $error("mask test stored or flagged wrong");
  xor_store_a: assert property (in_exe && is_alu && hi == `BAO_OP_XOR |->
    core_wen && core_wdata == (dst_q ^ b_val) ##1 !flags_q.v)
    else $error("xor store wrong");
  carry_set_a: assert property (in_exe && instr_q.opcode == `BAO_OPC_CARRY_SET |=>
    flags_q.c && pc_q == $past(pc_q) + 16'h0001)
    else $error("carry set op wrong");
  mask_write_a: assert property (axi_wfire && w_strb0_q && !aw_addr_q[`BAO_AXI_UNMAPPED_BIT] &&
    aw_addr_q[10:2] == {1'b0, `BAO_OFS_INTERRUPT_MASK} |=> interrupt_mask_q == $past(w_data_q))
    else $error("interrupt mask not written");

endmodule

// >>> byte_alu_op_decoder_bench.sv
// byte_alu_op_decoder_bench.sv: self-checking bench for bao_core.
// assumes bao_pkg is compiled first; the bench is the only bus and instruction master.
`timescale 1ns/1ps
module byte_alu_op_decoder_bench import bao_pkg::*;;
  logic mclk = 1'b0, rst = 1'b1, ce = 1'b1, instr_valid = 1'b0;
  logic instr_ready, exec_done, bad_opcode, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd_val;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp;
  logic [15:0] pc, exp_pc = 16'h0000;
  bao_instr_t instr = '0;
  int errors = 0, tests_run = 0;
  always #2 mclk = ~mclk;
  bao_core dut (.mclk, .rst, .ce, .instr_valid, .instr_ready, .instr, .pc, .exec_done,
    .bad_opcode, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ready is combinational, so it is judged at the falling edge where it is settled
  task automatic wr(input logic [7:0] r, input logic [7:0] d);
    logic ta, tw;
    @(posedge mclk);
    s_axi_awaddr <= {2'b00, r, 2'b00};
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    @(negedge mclk);
    while (s_axi_awvalid || s_axi_wvalid) begin
      ta = s_axi_awready === 1'b1;
      tw = s_axi_wready === 1'b1;
      @(posedge mclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      @(negedge mclk);
    end
    while (s_axi_bvalid !== 1'b1) @(negedge mclk);
    chk(32'(s_axi_bresp), 32'h0000_0000);
    @(posedge mclk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    @(negedge mclk);
    while (s_axi_arready !== 1'b1) @(negedge mclk);
    @(posedge mclk);
    s_axi_arvalid <= 1'b0;
    @(negedge mclk);
    while (s_axi_rvalid !== 1'b1) @(negedge mclk);
    rd_val = s_axi_rdata;
    rd_resp = s_axi_rresp;
    @(posedge mclk);
    s_axi_rready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] r, input logic [7:0] e);
    rd({2'b00, r, 2'b00});
    chk(rd_val, {24'h00_0000, e});
  endtask
  task automatic ex(input logic [7:0] op, a1, a2, input logic [15:0] np);
    int n;
    @(posedge mclk);
    instr <= {op, a1, a2};
    instr_valid <= 1'b1;
    @(negedge mclk);
    while (instr_ready !== 1'b1) @(negedge mclk);
    @(posedge mclk);
    instr_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (exec_done !== 1'b1 && n < 50);
    exp_pc = np;
    chk(32'(n), 32'h0000_0006);
    chk(32'(bad_opcode), 32'h0000_0000);
    chk(32'(pc), 32'(np));
  endtask
////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    for (int i = 0; i < 5; i++) begin
      rchk(8'hfb + 8'(i), 8'h00);
      wr(8'hfb + 8'(i), 8'ha5 ^ 8'(i));
      rchk(8'hfb + 8'(i), 8'ha5 ^ 8'(i));
    end
    wr(8'hfd, 8'h00);
    rd(12'h800);
    chk(32'(rd_resp), 32'h0000_0002);
  endtask
  // half-carry after a subtract is masked: its borrow sense is not pinned down
  task automatic t_alu(input logic [7:0] f);
    logic [3:0] ops [6] = '{4'h4, 4'hb, 4'h2, 4'h3, 4'h7, 4'h6};
    logic [7:0] a = 8'h3c, b = 8'ha5, r, e, m;
    logic [8:0] t;
    for (int i = 0; i < 6; i++) begin
      wr(8'h10, a);
      wr(8'hfc, f);
      ex({ops[i], 4'h6}, 8'h10, b, exp_pc + 16'h0003);
      t = {1'b0, a} - {1'b0, b} - {8'h00, f[7] & ops[i][0]};
      case (ops[i])
        4'h4: r = a | b;
        4'hb: r = a ^ b;
        4'h7: r = a & b;
        4'h6: r = ~a & b;
        default: r = t[7:0];
      endcase
      e = {f[7], r == 8'h00, r[7], 1'b0, f[3:0]};
      m = 8'hff;
      if (ops[i] < 4'h4) begin
        e[7] = t[8];
        e[4] = (a[7] != b[7]) && (r[7] != a[7]);
        e[3] = 1'b1;
        m = 8'hfb;
      end
      rchk(8'h10, (ops[i] inside {4'h6, 4'h7}) ? a : r);
      rd(12'h3f0);
      chk(rd_val & 32'(m), 32'(e & m));
    end
  endtask
  task automatic t_stack;
    wr(8'hff, 8'h80);
    wr(8'h20, 8'h77);
    wr(8'hfc, 8'h5a);
    ex(8'h70, 8'h20, 8'h00, exp_pc + 16'h0002);
    rchk(8'hff, 8'h7f);
    rchk(8'h7f, 8'h77);
    ex(8'h50, 8'h21, 8'h00, exp_pc + 16'h0002);
    rchk(8'h21, 8'h77);
    rchk(8'hff, 8'h80);
    wr(8'h80, 8'h12);
    wr(8'h81, 8'h34);
    ex(8'haf, 8'h00, 8'h00, 16'h1234);
    rchk(8'hff, 8'h82);
    rchk(8'hfc, 8'h5a);
    ex(8'hdf, 8'h00, 8'h00, exp_pc + 16'h0001);
    rchk(8'hfc, 8'hda);
    ex(8'hcf, 8'h00, 8'h00, exp_pc + 16'h0001);
    rchk(8'hfc, 8'h5a);
    wr(8'h23, 8'h30);
    wr(8'hfd, 8'h20);
    ex(8'h46, 8'he3, 8'h0f, exp_pc + 16'h0003);
    wr(8'hfd, 8'h00);
    rchk(8'h23, 8'h3f);
  endtask
  // remaining operand modes, indirect stack forms, an expanded group, single-byte ops
  task automatic t_modes;
    wr(8'hfd, 8'h10);
    wr(8'h12, 8'h0f);
    wr(8'h13, 8'h30);
    wr(8'h14, 8'h30);
    wr(8'h15, 8'h33);
    wr(8'h30, 8'h55);
    wr(8'h31, 8'h0a);
    ex(8'h42, 8'h23, 8'h00, exp_pc + 16'h0002);
    rchk(8'h12, 8'h3f);
    ex(8'hb3, 8'h24, 8'h00, exp_pc + 16'h0002);
    rchk(8'h12, 8'h6a);
    ex(8'h24, 8'h31, 8'h12, exp_pc + 16'h0003);
    rchk(8'h12, 8'h60);
    ex(8'h45, 8'he4, 8'h12, exp_pc + 16'h0003);
    rchk(8'h12, 8'h75);
    ex(8'hb7, 8'h14, 8'hff, exp_pc + 16'h0003);
    rchk(8'h30, 8'haa);
    ex(8'h71, 8'h14, 8'h00, exp_pc + 16'h0002);
    rchk(8'h81, 8'haa);
    ex(8'h51, 8'h15, 8'h00, exp_pc + 16'h0002);
    rchk(8'h33, 8'haa);
    wr(8'hfd, 8'h13);
    wr(8'hff, 8'h81);
    ex(8'h50, 8'h05, 8'h00, exp_pc + 16'h0002);
    rd(12'h4d4);
    chk(rd_val, 32'h0000_00aa);
    wr(8'hfc, 8'h00);
    ex(8'hef, 8'h00, 8'h00, exp_pc + 16'h0001);
    rchk(8'hfc, 8'h80);
    ex(8'h8f, 8'h00, 8'h00, exp_pc + 16'h0001);
    rchk(8'hfb, 8'h25);
  endtask
////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    t_regs;
    t_alu(8'hdd);
    t_alu(8'h00);
    t_stack;
    t_modes;
    final_report;
  end
  // the whole sequence needs well under a thousand cycles; the 50000-cycle limit leaves ample margin
  initial begin
    #200000;
    errors++;
    final_report;
  end
endmodule
